// ### src/asb_slave.sv
// Setup option registers and bus control for the dual serial adapter card.
// Assumes bus pins are asynchronous to ref_clk_i and the data bus is resolved
// outside from the enable and output values given here.
// Every pin passes two flops, so the card answers about three clocks after
// the host moves a line; the host must hold each command long enough.
// Only the setup block, the channel decodes and the cycle extension live
// here; the UART, the data buffer and the arbiter sit elsewhere.
`timescale 1ns/10ps
module asb_slave (
  input  wire logic        ref_clk_i,                   // 40 MHz clock
  input  wire logic        rstn_i,                      // Synchronous reset, low
  input  wire logic        channel_reset_i,             // Bus channel reset, high
  input  wire logic        card_setup_select_n_i,       // Setup select, low
  input  wire logic        cmd_n_i,                     // Command strobe, low
  input  wire logic        bus_status_zero_n_i,         // Status zero, low
  input  wire logic        bus_status_one_n_i,          // Status one, low
  input  wire logic        mem_io_i,                    // High memory, low I/O
  input  wire logic        refresh_n_i,                 // Refresh cycle, low
  input  wire logic [15:0] addr_i,                      // Bus address
  input  wire logic [7:0]  data_i,                      // Data pins in
  output logic      [7:0]  data_o,                      // Data pins out
  output logic      [7:0]  data_oe_o,                   // Per bit drive enable
  output logic             card_selected_feedback_n_o,  // Select feedback, low
  output logic             card_wide_size_flag_n_o,     // Data size 16, low
  output logic             channel_ready_out_o,         // Ready, low stretches
  output logic             channel_check_o,             // Open-collector value
  output logic             channel_check_oe_o,          // Drive enable
  output logic             io_read_strobe_o,            // Internal I/O read
  output logic             io_write_strobe_o,           // Internal I/O write
  output logic             id_low_read_strobe_o,        // ID low byte read
  output logic             id_high_read_strobe_o,       // ID high byte read
  output logic             card_enable_bit_o,           // Card enable
  output logic             fairness_en_o,               // Fairness enable
  output logic             ch1_match_o,                 // Channel 1 decode
  output logic             ch2_match_o,                 // Channel 2 decode
  output logic             dma_reg_sel_o,               // DMA register decode
  output logic      [3:0]  rx1_vector_bit_o,            // Channel 1 rx vector
  output logic      [3:0]  rx2_vector_bit_o,            // Channel 2 rx vector
  output logic      [3:0]  tx1_vector_bit_o,            // Channel 1 tx vector
  output logic             sync_ext_mode_o              // Synchronous extension
);
  import asb_pkg::*;

  // All state in one record
  // Keeping every flop in one packed record means reset and the next-state
  // copy cover everything at once, so no flop can be left out of either.
  typedef struct packed {
    logic [4:0]  s1_setup;      // First synchroniser stage, read only by s2
    logic [4:0]  s2_setup;      // {setup,cmd,s0,s1,refresh} synced
    logic [1:0]  s1_misc;       // {mem_io, reset} first stage
    logic [1:0]  s2_misc;
    logic [15:0] s1_addr;
    logic [15:0] s2_addr;
    logic [7:0]  s1_data;
    logic [7:0]  s2_data;
    logic [7:0]  opt2;          // Enable and decode select
    logic [7:0]  opt3;          // Upper address match
    logic [7:0]  opt4;          // Receiver vectors
    logic [7:0]  opt5;          // Tx vector and bus mode
    logic [7:0]  opt6;          // Subaddress low
    logic [7:0]  opt7;          // Subaddress high
    logic        cmd_prev;      // Command level last cycle
    logic [7:0]  wait_cnt;      // Cycles of not-ready so far
    logic        ready;         // Ready output
    logic [7:0]  rdata;         // Read data
    logic [7:0]  roe;           // Read drive enables
    asb_phase_t  phase;         // Extension phase
  } asb_state_t;

  asb_state_t st_q;
  asb_state_t st_d;

  // Synchronised views
  // Pins other than channel reset are active low; these names are active high so the decode below
  // reads as plain logic. Only second-stage values are ever used.
  logic        setup_act;
  logic        cmd_act;
  logic        st0_act;
  logic        st1_act;
  logic        refresh_act;
  logic        io_cyc;
  logic        channel_reset;
  logic [15:0] a;
  logic        io_read_strobe;
  logic        io_write_strobe;
  logic        card_sel;
  logic        cmd_fall;
  logic        in_setup_blk;

  assign setup_act   = ~st_q.s2_setup[4];
  assign cmd_act     = ~st_q.s2_setup[3];
  assign st0_act     = ~st_q.s2_setup[2];
  assign st1_act     = ~st_q.s2_setup[1];
  assign refresh_act = ~st_q.s2_setup[0];
  assign io_cyc      = ~st_q.s2_misc[1];
  assign channel_reset     = st_q.s2_misc[0];
  assign a           = st_q.s2_addr;

  // I/O strobes, suppressed during refresh
  assign io_read_strobe = cmd_act & io_cyc & ~refresh_act &
               ({st1_act, st0_act} == ASB_ST_READ);
  assign io_write_strobe = cmd_act & io_cyc & ~refresh_act &
               ({st1_act, st0_act} == ASB_ST_WRITE);

  // Channel decodes: fixed bits plus option terms, gated by card enable
  // A15, A11 and A10 are zero and A9, A5 one for every standard port, so
  // they are checked once. A7, A6 and A4 fold into a single term that is
  // high only when all three are low; A8 and A3 are compared directly.
  // The three upper bits come from the upper address match register.
  logic ch1_hit;
  logic ch2_hit;
  logic fixed_ok;
  logic a764;
  assign fixed_ok = ~(a[15] | a[11] | a[10]) & a[9] & a[5];
  assign a764     = ~(a[7] | a[6] | a[4]);
  assign ch1_hit  = fixed_ok & (a764 == st_q.opt2[6]) & (a[8] == st_q.opt2[5])
                    & (a[3] == st_q.opt2[4]) & (a[14:12] == st_q.opt3[5:3]);
  assign ch2_hit  = fixed_ok & (a764 == st_q.opt2[3]) & (a[8] == st_q.opt2[2])
                    & (a[3] == st_q.opt2[1]) & (a[14:12] == st_q.opt3[2:0]);

  // Decodes never act in setup, during refresh, or on memory cycles
  logic gate;
  assign gate = st_q.opt2[ASB_B_EN] & io_cyc & ~refresh_act & ~setup_act;
  assign ch1_match_o   = gate & ch1_hit;
  assign ch2_match_o   = gate & ch2_hit;
  assign dma_reg_sel_o = gate & (a == ASB_DMA_REG);
  assign card_sel      = ch1_match_o | ch2_match_o | dma_reg_sel_o;
  assign card_selected_feedback_n_o = ~card_sel;
  assign card_wide_size_flag_n_o    = 1'b1;
  assign channel_check_o    = 1'b0;
  assign channel_check_oe_o = 1'b0;
  assign io_read_strobe_o   = io_read_strobe;
  assign io_write_strobe_o  = io_write_strobe;
  assign in_setup_blk       = setup_act & (a[15:3] == ASB_ADDR_ID_LO[15:3]);
  assign id_low_read_strobe_o  = in_setup_blk & io_read_strobe & (a == ASB_ADDR_ID_LO);
  assign id_high_read_strobe_o = in_setup_blk & io_read_strobe & (a == ASB_ADDR_ID_HI);
  assign cmd_fall = cmd_act & ~st_q.cmd_prev;

  // Register outputs
  assign card_enable_bit_o = st_q.opt2[ASB_B_EN];
  assign fairness_en_o     = st_q.opt2[ASB_B_FAIR];
  assign rx2_vector_bit_o  = st_q.opt4[7:4];
  assign rx1_vector_bit_o  = st_q.opt4[3:0];
  assign tx1_vector_bit_o  = st_q.opt5[3:0];
  assign sync_ext_mode_o   = st_q.opt5[ASB_B_SYNC];
  assign channel_ready_out_o = st_q.ready;
  assign data_o    = st_q.rdata;
  assign data_oe_o = st_q.roe;

  // Next state
  // Synchroniser stages first, then read drive, setup writes, the cycle
  // extension machine and last the channel reset, which therefore wins
  // over any write or extension that falls in the same cycle.
  always_comb begin
    st_d = st_q;
    st_d.s1_setup = {card_setup_select_n_i, cmd_n_i, bus_status_zero_n_i,
                     bus_status_one_n_i, refresh_n_i};
    st_d.s2_setup = st_q.s1_setup;
    st_d.s1_misc  = {mem_io_i, channel_reset_i};
    st_d.s2_misc  = st_q.s1_misc;
    st_d.s1_addr  = addr_i;
    st_d.s2_addr  = st_q.s1_addr;
    st_d.s1_data  = data_i;
    st_d.s2_data  = st_q.s1_data;
    st_d.cmd_prev = cmd_act;
    // Read drive: ID reads only pull zero bits low, the pull-ups give ones
    st_d.rdata = ASB_OPT_RESET;
    st_d.roe   = ASB_OPT_RESET;
    if (in_setup_blk && io_read_strobe) begin
      case (a)
        ASB_ADDR_ID_LO: st_d.roe = ~ASB_ID_LO;
        ASB_ADDR_ID_HI: st_d.roe = ~ASB_ID_HI;
        ASB_ADDR_OPT2: begin
          st_d.rdata = st_q.opt2;
          st_d.roe   = 8'hff;
        end
        ASB_ADDR_OPT3: begin
          st_d.rdata = st_q.opt3;
          st_d.roe   = 8'hff;
        end
        ASB_ADDR_OPT4: begin
          st_d.rdata = st_q.opt4;
          st_d.roe   = 8'hff;
        end
        ASB_ADDR_OPT5: begin
          st_d.rdata = st_q.opt5;
          st_d.roe   = 8'hff;
        end
        ASB_ADDR_OPT6: begin
          st_d.rdata = st_q.opt6;
          st_d.roe   = 8'hff;
        end
        ASB_ADDR_OPT7: begin
          st_d.rdata = st_q.opt7;
          st_d.roe   = 8'hff;
        end
        default: st_d.roe = ASB_OPT_RESET;
      endcase
    end
    // Setup writes; ID bytes ignore writes
    if (in_setup_blk && io_write_strobe && cmd_fall) begin
      case (a)
        ASB_ADDR_OPT2: st_d.opt2 = st_q.s2_data;
        ASB_ADDR_OPT3: st_d.opt3 = st_q.s2_data;
        ASB_ADDR_OPT4: st_d.opt4 = st_q.s2_data;
        ASB_ADDR_OPT5: st_d.opt5 = st_q.s2_data;
        ASB_ADDR_OPT6: st_d.opt6 = st_q.s2_data;
        ASB_ADDR_OPT7: st_d.opt7 = st_q.s2_data;
        default: st_d.opt7 = st_q.opt7;
      endcase
    end
    // Cycle extension on every card access
    // Not-ready falls one clock after the synced command edge with a hit.
    // Synchronous mode frees it after one clock; asynchronous mode holds a
    // fixed number of wait states, kept well under the longest legal hold.
    // The done phase waits for the command to end so one access stretches once.
    case (st_q.phase)
      ASB_IDLE: begin
        st_d.ready = 1'b1;
        if (card_sel && cmd_fall) begin
          st_d.ready    = 1'b0;
          st_d.wait_cnt = ASB_CNT_ONE;
          st_d.phase    = ASB_WAIT;
        end
      end
      ASB_WAIT: begin
        st_d.wait_cnt = st_q.wait_cnt + ASB_CNT_ONE;
        if (st_q.opt5[ASB_B_SYNC]) begin
          if (st_q.wait_cnt >= 8'(ASB_SYNC_CYC)) begin
            st_d.ready = 1'b1;
            st_d.phase = ASB_DONE;
          end
        end else if (st_q.wait_cnt >= 8'(ASB_HOLD_CYC) ||
                     st_q.wait_cnt >= 8'(ASB_ASYNC_CYC)) begin
          st_d.ready = 1'b1;
          st_d.phase = ASB_DONE;
        end
      end
      ASB_DONE: begin
        st_d.ready = 1'b1;
        if (!cmd_act) st_d.phase = ASB_IDLE;
      end
      default: st_d.phase = ASB_IDLE;
    endcase
    // Channel reset clears options and state machines
    // Clearing the enable leaves the card silent until software sets it again.
    if (channel_reset) begin
      st_d.opt2     = ASB_OPT_RESET;
      st_d.opt3     = ASB_OPT_RESET;
      st_d.opt4     = ASB_OPT_RESET;
      st_d.opt5     = ASB_OPT_RESET;
      st_d.opt6     = ASB_OPT_RESET;
      st_d.opt7     = ASB_OPT_RESET;
      st_d.phase    = ASB_IDLE;
      st_d.ready    = 1'b1;
      st_d.wait_cnt = ASB_CNT_ZERO;
    end
  end

  // State register
  // The s1_setup and s2_setup stages reset to the idle pin levels; resetting them to zero
  // would look like an active setup and command for the first two clocks.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      st_q          <= '0;
      st_q.s1_setup <= 5'h1f;
      st_q.s2_setup <= 5'h1f;
      st_q.ready    <= 1'b1;
      st_q.phase    <= ASB_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Checks
  // All checks run on the one clock and are off while rstn_i is low.
  // Setup writes that land in the option block this cycle
  sequence s_opt_write;
    in_setup_blk && io_write_strobe && cmd_fall && !channel_reset;
  endsequence
  // One wait state, then ready again
  sequence s_one_wait;
    !channel_ready_out_o ##1 channel_ready_out_o;
  endsequence
  // Start of an extended access
  sequence s_ext_start;
    card_sel && cmd_fall && st_q.phase == ASB_IDLE && !channel_reset;
  endsequence
  a_ext_request: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_ext_start |=> !channel_ready_out_o) else $error("no extension on access");
  a_sync_release: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (s_ext_start and sync_ext_mode_o) |=> ##[0:2] channel_ready_out_o)
    else $error("sync not-ready held too long");
  a_async_limit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $fell(channel_ready_out_o) |-> ##[1:120] channel_ready_out_o)
    else $error("not-ready over limit");
  a_feedback_dec: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    card_selected_feedback_n_o == !(ch1_match_o || ch2_match_o || dma_reg_sel_o))
    else $error("feedback mismatch");
  a_enable_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !card_enable_bit_o |-> card_selected_feedback_n_o) else $error("decode while off");
  a_reset_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    channel_reset |=> !card_enable_bit_o && rx1_vector_bit_o == 4'h0)
    else $error("options not cleared");
  a_wide_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    card_wide_size_flag_n_o && !channel_check_oe_o) else $error("size or check driven");
  a_strobe_excl: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !(io_read_strobe_o && io_write_strobe_o)) else $error("both strobes");
  a_refresh_ign: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    refresh_act |-> !io_read_strobe_o && card_selected_feedback_n_o)
    else $error("refresh not ignored");
  a_id_drive: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    id_low_read_strobe_o |=> data_oe_o == ~ASB_ID_LO) else $error("id pull wrong");
  // High identity byte is also pull-low only, never driven high
  a_id_high_drive: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    id_high_read_strobe_o |=> data_oe_o == ~ASB_ID_HI && data_o == ASB_OPT_RESET)
    else $error("id high pull wrong");
  // A setup write to the enable register lands one clock later
  a_opt2_land: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (s_opt_write and (a == ASB_ADDR_OPT2)) |=> st_q.opt2 == $past(st_q.s2_data))
    else $error("option write lost");
  // Writes to the identity bytes change no option register
  a_id_no_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (s_opt_write and (a[15:1] == ASB_ADDR_ID_LO[15:1]))
    |=> $stable(st_q.opt2) && $stable(st_q.opt7))
    else $error("id write took effect");
  // Option reads drive the full byte from the register
  a_read_data: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (in_setup_blk && io_read_strobe && a == ASB_ADDR_OPT5)
    |=> data_o == $past(st_q.opt5) && data_oe_o == 8'hff)
    else $error("option read wrong");
  // Identity strobes only while the slot is in setup
  a_setup_only: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !setup_act |-> !id_low_read_strobe_o && !id_high_read_strobe_o)
    else $error("id strobe outside setup");
  // No channel decode while the slot is in setup
  a_setup_decode: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    setup_act |-> card_selected_feedback_n_o && !ch1_match_o && !ch2_match_o)
    else $error("decode during setup");
  // Memory cycles give no I/O strobe and no select
  a_mem_cycle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !io_cyc |-> !io_read_strobe_o && !io_write_strobe_o && card_selected_feedback_n_o)
    else $error("memory cycle decoded");
  // Synchronous mode gives exactly one wait state
  a_sync_short: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (s_ext_start and sync_ext_mode_o) |=> s_one_wait)
    else $error("sync wait not one cycle");
  // Asynchronous mode holds the chosen number of wait states
  // A channel reset in mid-access ends the stretch early, so it disables this
  a_async_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || channel_reset)
    (s_ext_start and !sync_ext_mode_o) |=> !channel_ready_out_o [*8] ##1 channel_ready_out_o)
    else $error("async hold length wrong");
  // Once the stretch is over, ready stays high for the rest of the command
  a_done_ready: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    st_q.phase == ASB_DONE |-> channel_ready_out_o)
    else $error("not-ready after release");
  // Channel reset returns the extension machine to idle
  a_channel_reset_fsm: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    channel_reset |=> channel_ready_out_o && st_q.phase == ASB_IDLE && st_q.wait_cnt == ASB_CNT_ZERO)
    else $error("extension not reset");
endmodule // asb_slave

// ### src/asb_pkg.sv
// Constants, register map and timing for the adapter setup bus slave.
// Assumes a 40 MHz ref_clk_i; all bus pins are asynchronous to it.
// How it works
// - Setup select low opens option register block
// - ID bytes read-only, option bytes read/write
// - ID low/high bytes with separate read strobes
// - ID reads pull bits low, rest pulled up
// - Card enable gates the channel and DMA decodes
// - Option bit 7 enables arbitration fairness
// - Option bits hold channel decode terms
// - Upper address bits compared per channel
// - Receiver DMA vectors held and driven out
// - Transmitter vector held and driven out
// - Bus mode bit selects synchronous extension
// - Channel check bits unused by this card
// - Card selected feedback low on decode
// - Wide data size flag kept inactive high
// - Synchronous mode releases not-ready quickly
// - Asynchronous not-ready never beyond 3 us
// - Every card access requests cycle extension
// - Channel reset clears interface state machines
// - Refresh cycles are ignored entirely
// - Channel check open-collector, kept inactive
// - Status and command decode into I/O strobes
package asb_pkg;
  localparam logic [15:0] ASB_ADDR_ID_LO  = 16'h0100;
  localparam logic [15:0] ASB_ADDR_ID_HI  = 16'h0101;
  localparam logic [15:0] ASB_ADDR_OPT2   = 16'h0102;
  localparam logic [15:0] ASB_ADDR_OPT3   = 16'h0103;
  localparam logic [15:0] ASB_ADDR_OPT4   = 16'h0104;
  localparam logic [15:0] ASB_ADDR_OPT5   = 16'h0105;
  localparam logic [15:0] ASB_ADDR_OPT6   = 16'h0106;
  localparam logic [15:0] ASB_ADDR_OPT7   = 16'h0107;
  localparam logic [15:0] ASB_DMA_REG     = 16'h02f7;  // Fixed DMA control/status address
  localparam logic [7:0]  ASB_OPT_RESET   = 8'h00;
  // Card identity bytes: arbitrary neutral values
  localparam logic [7:0]  ASB_ID_LO       = 8'h5a;
  localparam logic [7:0]  ASB_ID_HI       = 8'h3c;
  // Field positions
  localparam int ASB_B_EN     = 0;
  localparam int ASB_B_FAIR   = 7;
  localparam int ASB_B_SYNC   = 5;
  // Timing
  localparam int ASB_CLK_NS       = 25;
  localparam int ASB_SYNC_REL_NS  = 30;    // Longest time to release not-ready
  localparam int ASB_ASYNC_MAX_NS = 3000;  // Longest not-ready hold
  localparam int ASB_SYNC_CYC  = (ASB_SYNC_REL_NS / ASB_CLK_NS) < 1 ? 1 :
                                 (ASB_SYNC_REL_NS / ASB_CLK_NS);
  localparam int ASB_ASYNC_CYC = ASB_ASYNC_MAX_NS / ASB_CLK_NS;
  localparam int ASB_HOLD_CYC  = 8;        // Wait states wanted in asynchronous mode
  localparam logic [7:0] ASB_CNT_ONE = 8'h01;
  localparam logic [7:0] ASB_CNT_ZERO = 8'h00;
  // Command decode of status lines (as active-high views)
  localparam logic [1:0] ASB_ST_WRITE = 2'b10;  // {status_one,status_zero}
  localparam logic [1:0] ASB_ST_READ  = 2'b01;
  typedef enum {ASB_IDLE, ASB_WAIT, ASB_DONE} asb_phase_t;
endpackage : asb_pkg

// ### tb/asb_host_model.sv
// Host side of the expansion bus: runs setup and I/O commands on the card.
// Assumes the bench resolves the pulled-up data bus and returns it on bus_i.
`timescale 1ns/10ps
module asb_host_model #(
  parameter int HOLD = 14                    // Strobe low span, covers the longest stretch
) (
  input  wire logic        ref_clk_i,        // Bus timing reference
  input  wire logic [7:0]  bus_i,            // Resolved data bus
  input  wire logic        ready_i,          // Channel ready, low stretches
  input  wire logic        fb_n_i,           // Select feedback, low
  output logic             setup_n_o,        // Setup select, low
  output logic             cmd_n_o,          // Command strobe, low
  output logic             s0_n_o,           // Status zero, low
  output logic             s1_n_o,           // Status one, low
  output logic             mem_io_o,         // High memory, low I/O
  output logic             refresh_n_o,      // Refresh, low
  output logic [15:0]      addr_o,           // Address
  output logic [7:0]       wdata_o,          // Data we drive
  output logic             drive_o           // High while we drive data
);
  int   lo_cnt;   // Edges seen not ready during the strobe
  logic fb_seen;  // Feedback went low during the command
  initial begin
    {setup_n_o, cmd_n_o, s0_n_o, s1_n_o, refresh_n_o} = 5'h1f;
    {mem_io_o, drive_o} = 2'h0;
    addr_o  = 16'h0000;
    wdata_o = 8'h00;
  end
  // One command; answer taken at the last edge before the strobe rises
  task automatic cycle(input logic wr, input logic stp, input logic mem, input logic rf,
                       input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk_i);
    setup_n_o   = ~stp;
    mem_io_o    = mem;
    refresh_n_o = ~rf;
    addr_o      = a;
    wdata_o     = d;
    drive_o     = wr;
    s0_n_o      = wr;
    s1_n_o      = ~wr;
    @(negedge ref_clk_i);
    cmd_n_o = 1'b0;
    lo_cnt  = 0;
    fb_seen = 1'b0;
    // Wait-state count kept by the host side of the extension
    repeat (HOLD) begin
      @(posedge ref_clk_i);
      if (ready_i !== 1'b1) lo_cnt++;
      if (fb_n_i === 1'b0) fb_seen = 1'b1;
      q = bus_i;
    end
    @(negedge ref_clk_i);
    {cmd_n_o, s0_n_o, s1_n_o, refresh_n_o} = 4'hf;
    drive_o = 1'b0;
    // Released lines show the inverse so stale values never pass
    addr_o  = ~a;
    wdata_o = ~d;
    repeat (3) @(negedge ref_clk_i);
  endtask
endmodule // asb_host_model

// ### tb/asb_slave_tb.sv
// Self-checking bench for the setup bus slave with a host model.
// Assumes a pulled-up data bus resolved here from all drive enables.
`timescale 1ns/10ps
module asb_slave_tb;
  import asb_pkg::*;
  logic ref_clk_i, rstn_i, channel_reset_i, setup_n, cmd_n, s0_n, s1_n, mem_io, rf_n, drv;
  logic [15:0] addr;
  logic [7:0]  wd, bus, dout, doe, rd;
  logic fb_n, wide_n, rdy, chk, chk_oe, iord, iowr, idlo, idhi, en, fair, m1, m2, dsel, sync;
  logic [3:0]  rx1, rx2, tx1;
  logic [6:0]  obs;                       // Sticky strobes and decodes of one command
  logic [7:0]  ta [7];                    // Decode table values
  int bad_count, num_checks;
  logic [15:0] tad [7];
  logic [7:0]  tex [7], tmk [7], tvl [5];
  // Pull-up wins wherever nobody drives a bit
  assign bus = (dout & doe) | (~doe & (drv ? wd : 8'hff));
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) obs <= obs | {iord, iowr, m1, m2, dsel, idlo, idhi};
  asb_slave u_asb_slave (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .channel_reset_i(channel_reset_i), .card_setup_select_n_i(setup_n), .cmd_n_i(cmd_n),
    .bus_status_zero_n_i(s0_n), .bus_status_one_n_i(s1_n), .mem_io_i(mem_io),
    .refresh_n_i(rf_n), .addr_i(addr), .data_i(bus), .data_o(dout), .data_oe_o(doe),
    .card_selected_feedback_n_o(fb_n), .card_wide_size_flag_n_o(wide_n),
    .channel_ready_out_o(rdy), .channel_check_o(chk), .channel_check_oe_o(chk_oe),
    .io_read_strobe_o(iord), .io_write_strobe_o(iowr), .id_low_read_strobe_o(idlo),
    .id_high_read_strobe_o(idhi), .card_enable_bit_o(en), .fairness_en_o(fair),
    .ch1_match_o(m1), .ch2_match_o(m2), .dma_reg_sel_o(dsel), .rx1_vector_bit_o(rx1),
    .rx2_vector_bit_o(rx2), .tx1_vector_bit_o(tx1), .sync_ext_mode_o(sync));
  asb_host_model u_asb_host_model (.ref_clk_i(ref_clk_i), .bus_i(bus), .ready_i(rdy),
    .fb_n_i(fb_n), .setup_n_o(setup_n), .cmd_n_o(cmd_n), .s0_n_o(s0_n), .s1_n_o(s1_n),
    .mem_io_o(mem_io), .refresh_n_o(rf_n), .addr_o(addr), .wdata_o(wd), .drive_o(drv));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus command through the host model
  task automatic go(input logic wr, input logic stp, input logic mem, input logic rf,
                    input logic [15:0] a, input logic [7:0] d);
    obs = 7'h00;
    u_asb_host_model.cycle(wr, stp, mem, rf, a, d, rd);
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 640 cycles the tests need
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    {ref_clk_i, rstn_i, channel_reset_i, bad_count, num_checks} = '0;
    obs = 7'h00;
    tvl = '{8'h03, 8'h53, 8'h27, 8'ha5, 8'h5a};
    // Decode table: {feedback, rd, wr, ch1, ch2, dma, wait states}
    tad = '{16'h02f8, 16'h3220, 16'h02f7, 16'h03f8, 16'h02f8, 16'h02f8, 16'h12f8};
    tex = '{8'hd1, 8'ha9, 8'hc5, 8'h00, 8'h00, 8'h00, 8'h00};
    tmk = '{8'hff, 8'hff, 8'hff, 8'h9f, 8'hff, 8'hff, 8'h9f};
    repeat (2) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    check(wide_n, 16'h1);
    check({chk, chk_oe}, 16'h0);
    go(0, 1, 0, 0, ASB_ADDR_ID_LO, 8'h00);
    check({rd, obs[1:0]}, {ASB_ID_LO, 2'b10});
    go(1, 1, 0, 0, ASB_ADDR_ID_HI, 8'h00);
    go(0, 1, 0, 0, ASB_ADDR_ID_HI, 8'h00);
    check({rd, obs[1:0]}, {ASB_ID_HI, 2'b01});
    for (int i = 2; i < 8; i++) begin
      go(0, 1, 0, 0, ASB_ADDR_ID_LO + 16'(i), 8'h00);
      check(rd, ASB_OPT_RESET);
    end
    for (int i = 0; i < 5; i++) go(1, 1, 0, 0, ASB_ADDR_OPT3 + 16'(i), tvl[i]);
    for (int i = 0; i < 5; i++) begin
      go(0, 1, 0, 0, ASB_ADDR_OPT3 + 16'(i), 8'h00);
      check(rd, tvl[i]);
    end
    check({rx2, rx1, tx1, 3'h0, sync}, 16'h5371);
    go(1, 1, 0, 0, ASB_ADDR_OPT2, 8'h98);
    check({en, fair}, 16'h1);
    go(1, 1, 0, 0, ASB_ADDR_OPT2, 8'h99);
    go(0, 1, 0, 0, ASB_ADDR_OPT2, 8'h00);
    check({rd, en}, 16'h133);
    for (int i = 0; i < 7; i++) begin
      go(i == 1, 0, i == 4, i == 5, tad[i], 8'h3c);
      check({u_asb_host_model.fb_seen, obs[6:2], 2'(u_asb_host_model.lo_cnt)} & tmk[i],
            tex[i]);
    end
    go(1, 1, 0, 0, ASB_ADDR_OPT5, 8'h07);
    check(sync, 16'h0);
    go(0, 0, 0, 0, 16'h02f8, 8'h00);
    check(u_asb_host_model.lo_cnt, ASB_HOLD_CYC);
    check(u_asb_host_model.lo_cnt < ASB_ASYNC_CYC, 16'h1);
    @(negedge ref_clk_i);
    channel_reset_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    channel_reset_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check({en, fair, sync, rx2, rx1, tx1}, 16'h0);
    go(0, 0, 0, 0, 16'h02f8, 8'h00);
    check({u_asb_host_model.fb_seen, obs[4], 2'(u_asb_host_model.lo_cnt)}, 16'h0);
    go(0, 1, 0, 0, ASB_ADDR_OPT2, 8'h00);
    check(rd, ASB_OPT_RESET);
    results();
  end
endmodule // asb_slave_tb
